// *** design/apl_pkg.sv ***
// Constants shared by the page auto-increment loader and its page memory
package apl_pkg;
    // ------------------------------------------------------------
    // Page geometry
    // ------------------------------------------------------------
    localparam int PAGE_BYTES = 128;
    localparam int BYTE_IDX_W = 7;
    localparam int LOAD_CNT_W = 8;
    localparam logic [7:0] PAGE_LAST_COUNT = 8'h80;
    localparam int PAGE_MSB = 20;
    localparam int PAGE_LSB = 7;
    localparam int FLASH_ADDR_W = 21;
    localparam int MEM_ADDR_W = 28;

    // ------------------------------------------------------------
    // Bus field encodings and cycle counts
    // ------------------------------------------------------------
    localparam logic [3:0] START_WRITE = 4'hE;
    localparam logic [2:0] ADDR_NIBBLES_LAST = 3'h6;

    // ------------------------------------------------------------
    // Buffer and programming timing
    // ------------------------------------------------------------
    localparam logic [7:0] GROUP_BYTES = 8'h04;
    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_BYTE_TIME_NS = 10000;
    localparam int PROG_BYTE_CYCLES_I = (PROG_BYTE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] PROG_BYTE_CYCLES = PROG_BYTE_CYCLES_I[11:0];

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        APL_IDLE,
        APL_CSEL,
        APL_ADDR,
        APL_SIZE,
        APL_DATA,
        APL_DRAIN
    } apl_state_e;
endpackage

// *** design/apl_page_mem.sv ***
// Page buffer memory: one write port, registered read data
`timescale 1ns/1ps
`default_nettype none
module apl_page_mem (
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem_reg [0:apl_pkg::PAGE_BYTES-1];

    // Write port
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge clk_sys) begin
        if (rd_en) begin
            rd_data <= mem_reg[rd_addr];
        end
    end
endmodule
`default_nettype wire

// *** design/apl_page_loader.sv ***
// Page auto-increment load and program sequencer
`timescale 1ns/1ps
`default_nettype none
module apl_page_loader (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [3:0] lad_in,
    input wire logic lframe_n,
    input wire logic high_voltage_mode_pin,
    input wire logic load_strobe_n,
    input wire logic [3:0] strap_select_pins,
    output logic ready_busy_n,
    output logic page_autoincrement_mode,
    output logic write_unlock_all,
    output logic flash_we,
    output logic [20:0] flash_addr,
    output logic [7:0] flash_data
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] pin_s1_reg;
    logic [5:0] pin_s2_reg;
    logic [5:0] pin_s3_reg;
    logic [5:0] pin_reg;
    logic mode_reg;
    logic ld_low;
    logic [3:0] strap;

    // Three stages, value taken when stages two and three agree
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_reg <= 6'h02;
            pin_s2_reg <= 6'h02;
            pin_s3_reg <= 6'h02;
            pin_reg <= 6'h02;
        end else begin
            pin_s1_reg <= {strap_select_pins, load_strobe_n, high_voltage_mode_pin};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            if (pin_s2_reg == pin_s3_reg) begin
                pin_reg <= pin_s3_reg;
            end
        end
    end

    assign ld_low = !pin_reg[1];
    assign strap = pin_reg[5:2];

    // Mode follows the supervoltage level
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= 1'b0;
        end else begin
            mode_reg <= pin_reg[0];
        end
    end

    // ------------------------------------------------------------
    // Load sequencer
    // ------------------------------------------------------------
    apl_pkg::apl_state_e state_reg;
    logic [2:0] nib_cnt_reg;
    logic [27:0] addr_sh_reg;
    logic [13:0] page_reg;
    logic [7:0] load_cnt_reg;
    logic phase_reg;
    logic [3:0] low_nib_reg;
    logic [7:0] prog_cnt_reg;
    logic [7:0] pending;
    logic accept;
    logic wr_en;
    logic [7:0] wr_data;
    logic drain_done;
    logic rd_pend_reg;
    logic [11:0] timer_reg;
    logic rd_go;
    logic [7:0] rd_data;

    assign pending = load_cnt_reg - prog_cnt_reg;
    // Nibble taken only while strobe low, ready shown and room left
    assign accept = (state_reg == apl_pkg::APL_DATA) && ld_low && ready_busy_n
        && (pending < apl_pkg::GROUP_BYTES) && (load_cnt_reg < apl_pkg::PAGE_LAST_COUNT);
    assign wr_en = accept && phase_reg;
    assign wr_data = {lad_in, low_nib_reg};
    assign drain_done = (prog_cnt_reg == load_cnt_reg) && !rd_pend_reg
        && (timer_reg == 12'h000) && !flash_we;

    // Frame state machine
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= apl_pkg::APL_IDLE;
        end else if (!mode_reg) begin
            state_reg <= apl_pkg::APL_IDLE;
        end else begin
            case (state_reg)
                apl_pkg::APL_IDLE, apl_pkg::APL_CSEL: begin
                    if (!lframe_n) begin
                        // Latest start while frame low wins
                        if (lad_in == apl_pkg::START_WRITE) begin
                            state_reg <= apl_pkg::APL_CSEL;
                        end else begin
                            state_reg <= apl_pkg::APL_IDLE;
                        end
                    end else if (state_reg == apl_pkg::APL_CSEL) begin
                        if (lad_in == strap) begin
                            state_reg <= apl_pkg::APL_ADDR;
                        end else begin
                            state_reg <= apl_pkg::APL_IDLE;
                        end
                    end
                end
                apl_pkg::APL_ADDR: begin
                    if (nib_cnt_reg == apl_pkg::ADDR_NIBBLES_LAST) begin
                        state_reg <= apl_pkg::APL_SIZE;
                    end
                end
                apl_pkg::APL_SIZE: begin
                    state_reg <= apl_pkg::APL_DATA;
                end
                apl_pkg::APL_DATA: begin
                    if (!ld_low || load_cnt_reg == apl_pkg::PAGE_LAST_COUNT) begin
                        state_reg <= apl_pkg::APL_DRAIN;
                    end
                end
                apl_pkg::APL_DRAIN: begin
                    if (drain_done) begin
                        state_reg <= apl_pkg::APL_IDLE;
                    end
                end
                default: begin
                    state_reg <= apl_pkg::APL_IDLE;
                end
            endcase
        end
    end

    // Address nibbles, most significant first
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nib_cnt_reg <= 3'h0;
            addr_sh_reg <= 28'h0000000;
        end else if (state_reg == apl_pkg::APL_ADDR) begin
            nib_cnt_reg <= nib_cnt_reg + 3'h1;
            addr_sh_reg <= {addr_sh_reg[23:0], lad_in};
        end else begin
            nib_cnt_reg <= 3'h0;
        end
    end

    // Page number kept, low seven bits and upper bits dropped
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            page_reg <= 14'h0000;
        end else if (state_reg == apl_pkg::APL_SIZE) begin
            page_reg <= addr_sh_reg[apl_pkg::PAGE_MSB:apl_pkg::PAGE_LSB];
        end
    end

    // Byte counter and nibble phase, cleared at each page address
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            load_cnt_reg <= 8'h00;
            phase_reg <= 1'b0;
            low_nib_reg <= 4'h0;
        end else if (state_reg == apl_pkg::APL_SIZE) begin
            load_cnt_reg <= 8'h00;
            phase_reg <= 1'b0;
        end else if (state_reg == apl_pkg::APL_DATA && !ld_low) begin
            phase_reg <= 1'b0;
        end else if (accept) begin
            phase_reg <= !phase_reg;
            if (!phase_reg) begin
                low_nib_reg <= lad_in;
            end else begin
                load_cnt_reg <= load_cnt_reg + 8'h01;
            end
        end
    end

    // Ready/busy: low when buffer full, page full or draining
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ready_busy_n <= 1'b1;
        end else if (state_reg == apl_pkg::APL_DRAIN) begin
            ready_busy_n <= 1'b0;
        end else if (state_reg == apl_pkg::APL_DATA) begin
            ready_busy_n <= (pending < apl_pkg::GROUP_BYTES)
                && (load_cnt_reg < apl_pkg::PAGE_LAST_COUNT);
        end else begin
            ready_busy_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Page buffer and programming engine
    // ------------------------------------------------------------
    assign rd_go = !rd_pend_reg && !flash_we && (timer_reg == 12'h000)
        && (prog_cnt_reg < load_cnt_reg);

    apl_page_mem u_mem (
        .clk_sys(clk_sys),
        .wr_en(wr_en),
        .wr_addr(load_cnt_reg[6:0]),
        .wr_data(wr_data),
        .rd_en(rd_go),
        .rd_addr(prog_cnt_reg[6:0]),
        .rd_data(rd_data)
    );

    // One byte at a time, each followed by the program time
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_pend_reg <= 1'b0;
            prog_cnt_reg <= 8'h00;
            timer_reg <= 12'h000;
            flash_we <= 1'b0;
            flash_addr <= 21'h000000;
            flash_data <= 8'h00;
        end else begin
            flash_we <= 1'b0;
            if (state_reg == apl_pkg::APL_SIZE) begin
                prog_cnt_reg <= 8'h00;
            end else if (rd_pend_reg) begin
                rd_pend_reg <= 1'b0;
                flash_we <= 1'b1;
                flash_addr <= {page_reg, prog_cnt_reg[6:0]};
                flash_data <= rd_data;
                prog_cnt_reg <= prog_cnt_reg + 8'h01;
                timer_reg <= apl_pkg::PROG_BYTE_CYCLES;
            end else if (timer_reg != 12'h000) begin
                timer_reg <= timer_reg - 12'h001;
            end else if (rd_go) begin
                rd_pend_reg <= 1'b1;
            end
        end
    end

    // Mode status and block lock override
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            page_autoincrement_mode <= 1'b0;
            write_unlock_all <= 1'b0;
        end else begin
            page_autoincrement_mode <= mode_reg;
            write_unlock_all <= mode_reg;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    AST_MODE_ONLY: assert property (state_reg != apl_pkg::APL_IDLE |-> $past(mode_reg))
        else $error("sequencer active without supervoltage mode");
    AST_START_FIELD: assert property (mode_reg && !lframe_n && lad_in == apl_pkg::START_WRITE
        && state_reg == apl_pkg::APL_IDLE |=> state_reg == apl_pkg::APL_CSEL)
        else $error("start field not recognised");
    AST_SELECT_MISMATCH: assert property (state_reg == apl_pkg::APL_CSEL && lframe_n
        && lad_in != strap |=> state_reg == apl_pkg::APL_IDLE)
        else $error("cycle taken with foreign select");
    AST_ADDR_SEVEN: assert property ($rose(state_reg == apl_pkg::APL_ADDR)
        |-> (state_reg == apl_pkg::APL_ADDR) [*7] ##1 state_reg == apl_pkg::APL_SIZE)
        else $error("address field not seven nibbles");
    AST_SIZE_SKIP: assert property (state_reg == apl_pkg::APL_SIZE && mode_reg
        |=> state_reg == apl_pkg::APL_DATA && load_cnt_reg == 8'h00 && !phase_reg)
        else $error("size nibble not skipped or counters not cleared");
    AST_PAGE_ADDR: assert property (flash_we |-> flash_addr[20:7] == page_reg
        && flash_addr[6:0] == 7'(prog_cnt_reg - 8'h01))
        else $error("programmed byte outside page order");
    AST_ACCEPT_READY: assert property (wr_en |-> ready_busy_n && ld_low
        && wr_data[3:0] == low_nib_reg)
        else $error("byte accepted while busy or strobe high");
    AST_FULL_BUSY: assert property (state_reg == apl_pkg::APL_DATA && mode_reg
        && pending >= apl_pkg::GROUP_BYTES |=> !ready_busy_n)
        else $error("ready shown with full buffer");
    AST_EARLY_END: assert property (state_reg == apl_pkg::APL_DATA && mode_reg && !ld_low
        |=> state_reg == apl_pkg::APL_DRAIN ##1 !ready_busy_n)
        else $error("early strobe rise not ending load");
    AST_DRAIN_DONE: assert property (state_reg == apl_pkg::APL_DRAIN && mode_reg && drain_done
        |=> state_reg == apl_pkg::APL_IDLE ##1 ready_busy_n)
        else $error("ready not restored after programming");
    AST_UNLOCK: assert property (mode_reg |=> write_unlock_all)
        else $error("blocks not unlocked in mode");

    COV_FULL_PAGE: cover property (load_cnt_reg == apl_pkg::PAGE_LAST_COUNT
        && state_reg == apl_pkg::APL_DRAIN);
    COV_PARTIAL: cover property (state_reg == apl_pkg::APL_DATA && !ld_low
        && load_cnt_reg != 8'h00 && phase_reg);
    COV_STALL: cover property (state_reg == apl_pkg::APL_DATA && !ready_busy_n);
    COV_FOREIGN: cover property (state_reg == apl_pkg::APL_CSEL && lframe_n && lad_in != strap);
endmodule
`default_nettype wire

// *** verification/apl_host_model.sv ***
// Host model that drives page load frames on the nibble bus
`timescale 1ns/1ps
`default_nettype none
module apl_host_model (
    input wire logic clk_sys,
    input wire logic ready_busy_n,
    output logic [3:0] lad_in,
    output logic lframe_n,
    output logic load_strobe_n,
    output logic high_voltage_mode_pin
);
    // Idle levels, pulled-up bus shows all ones
    initial begin
        lad_in = 4'hF;
        lframe_n = 1'b1;
        load_strobe_n = 1'b1;
        high_voltage_mode_pin = 1'b0;
    end

    // One nibble held for one clock, changed just after the edge
    task automatic put(input logic [3:0] nib, input logic frm_n);
        lframe_n = frm_n;
        lad_in = nib;
        @(posedge clk_sys);
        #1;
    endtask

    // Mode pin only moves while idle with strobe high
    task automatic set_mode(input logic on);
        high_voltage_mode_pin = on;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask

    // Whole frame: start, select, address, size, then data bytes
    task automatic frame(input logic [3:0] sel, input logic [27:0] addr, input int nbytes,
                         input bit stop_busy, input bit restart, input logic [7:0] base,
                         output int loaded);
        int nib;
        logic rb_pre;
        logic [7:0] b;
        nib = 0;
        load_strobe_n = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        if (restart) put(4'hE, 1'b0);
        put(4'hE, 1'b0);
        put(sel, 1'b1);
        for (int a = 6; a >= 0; a--) put(addr[a*4 +: 4], 1'b1);
        put(4'h3, 1'b1);
        // Nibble counts only if ready stood high across its edge
        while (nib < nbytes * 2) begin
            b = 8'(nib / 2) * 8'h03 + base;
            lad_in = nib[0] ? b[7:4] : b[3:0];
            rb_pre = ready_busy_n;
            @(posedge clk_sys);
            #1;
            if (rb_pre && ready_busy_n) nib++;
            else if (stop_busy && nib > 0) break;
        end
        lad_in = 4'hF;
        load_strobe_n = 1'b1;
        loaded = nib / 2;
    endtask
endmodule
`default_nettype wire

// *** verification/auto_increment_page_loader_tb.sv ***
// Self-checking bench for the page auto-increment loader
`timescale 1ns/1ps
`default_nettype none
module auto_increment_page_loader_tb;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] straps = 4'hA;
    logic [3:0] lad_in;
    logic lframe_n;
    logic load_strobe_n;
    logic hv_pin;
    logic ready_busy_n;
    logic mode_on;
    logic unlock_all;
    logic flash_we;
    logic [20:0] flash_addr;
    logic [7:0] flash_data;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [28:0] pulses[$];

    // Clock and instances
    always #25 clk_sys = ~clk_sys;

    apl_page_loader uut (.clk_sys(clk_sys), .arst_n(arst_n), .lad_in(lad_in),
        .lframe_n(lframe_n), .high_voltage_mode_pin(hv_pin), .load_strobe_n(load_strobe_n),
        .strap_select_pins(straps), .ready_busy_n(ready_busy_n),
        .page_autoincrement_mode(mode_on), .write_unlock_all(unlock_all),
        .flash_we(flash_we), .flash_addr(flash_addr), .flash_data(flash_data));

    apl_host_model host (.clk_sys(clk_sys), .ready_busy_n(ready_busy_n), .lad_in(lad_in),
        .lframe_n(lframe_n), .load_strobe_n(load_strobe_n), .high_voltage_mode_pin(hv_pin));

    // Programmed byte log and hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (flash_we === 1'b1) pulses.push_back({flash_addr, flash_data});
        if (cycles == 60000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Bounded wait for ready, then compare every programmed byte
    task automatic end_page(input logic [13:0] page, input int n, input logic [7:0] base);
        int w;
        w = 0;
        while (ready_busy_n !== 1'b1 && w < 5000) begin
            cyc(1);
            w++;
        end
        check(32'(w < 5000), 32'h1);
        check(32'(pulses.size()), 32'(n));
        for (int i = 0; i < n; i++)
            check({3'h0, pulses[i]}, {3'h0, page, 7'(i), 8'(i) * 8'h03 + base});
        pulses.delete();
    endtask

    task automatic t_after_reset();
        check({29'h0, ready_busy_n, mode_on, unlock_all}, 32'h4);
    endtask

    task automatic t_mode_off();
        int loaded;
        host.frame(4'hA, 28'h0001_000, 2, 1'b0, 1'b0, 8'h11, loaded);
        cyc(20);
        check(32'(pulses.size()), 32'h0);
        host.set_mode(1'b1);
        check({30'h0, mode_on, unlock_all}, 32'h3);
    endtask

    task automatic t_full_page();
        int loaded;
        logic [27:0] addr;
        addr = 28'hFE5_5ED5;
        host.frame(4'hA, addr, 128, 1'b0, 1'b0, 8'h5A, loaded);
        check(32'(loaded), 32'h80);
        cyc(6);
        check({31'h0, ready_busy_n}, 32'h0);
        end_page(addr[20:7], 128, 8'h5A);
    endtask

    task automatic t_partial();
        int loaded;
        logic [27:0] addr;
        addr = 28'h012_347F;
        straps = 4'h5;
        cyc(6);
        host.frame(4'h5, addr, 128, 1'b1, 1'b1, 8'hC3, loaded);
        check(32'(loaded > 0 && loaded < 128), 32'h1);
        cyc(6);
        check({31'h0, ready_busy_n}, 32'h0);
        end_page(addr[20:7], loaded, 8'hC3);
    endtask

    task automatic t_wrong_select();
        int loaded;
        host.frame(4'hA, 28'h0002_080, 3, 1'b0, 1'b0, 8'h07, loaded);
        cyc(20);
        check({31'h0, ready_busy_n}, 32'h1);
        check(32'(pulses.size()), 32'h0);
    endtask

    task automatic t_mode_exit();
        host.set_mode(1'b0);
        check({30'h0, mode_on, unlock_all}, 32'h0);
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        cyc(2);
        t_after_reset();
        t_mode_off();
        t_full_page();
        t_partial();
        t_wrong_select();
        t_mode_exit();
        finish_test();
    end
endmodule
`default_nettype wire
